/* File: hw/encoder_position_scaling.sv */
// Encoder position scaling top
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module encoder_position_scaling
   import scale_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,

   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,

   // Encoder measurement
   input  wire logic [31:0] raw_pos_in,
   input  wire logic [47:0] vel_raw_in,
   input  wire logic [31:0] off_revs_in,

   // Process outputs
   output logic [31:0]      position_out,
   output logic [31:0]      velocity_out,
   output logic [7:0]       status_byte_out,
   output logic             alarm_out,
   output logic [15:0]      alarm_type_out,
   output logic             param_err_out,

   // Velocity and channel settings
   output logic [2:0]       vel_unit_out,
   output logic [3:0]       filt_level_out,
   output logic             filt_dyn_out,
   output logic [15:0]      vel_factor_out,
   output logic [15:0]      int_time_out,
   output logic [15:0]      window_out
);
   typedef struct packed {
      fsm_t              fsm;
      cfg_t              cfg;
      logic [4:0][31:0]  rec;
      logic [31:0]       preset_val;
      logic              commit_pend;
      logic              preset_pend;
      logic              grade_high;
      logic [29:0]       offset;
      logic [29:0]       base;
      logic [79:0]       div_a;
      logic [31:0]       div_b;
      logic              div_start;
      logic [31:0]       position;
      logic [31:0]       velocity;
      logic [31:0]       rdata;
      logic              vel_err;
      logic              preset_err;
      logic              scale_err;
      logic              alarm;
      logic              param_err;
   } top_state_t;

   localparam cfg_t CFG_RESET = '{
      dir: 1'b1,
      range: RANGE_MAX[29:0],
      num: NUM_DEFAULT[17:0],
      den: DEN_DEFAULT[14:0],
      vel_unit: 3'h1,
      filt_level: 4'h0,
      filt_dyn: 1'b0,
      vel_factor: 16'h0001,
      int_time: 16'h0064,
      window: 16'h03e8};

   logic [1:0]  rst_sync_q;
   logic        rst_sync_n;

   top_state_t  s_q;
   top_state_t  s_d;
   cfg_t        dec_cfg;
   logic        dec_valid;
   logic        dec_nondefault;

   logic [31:0] revs_limit;
   logic [30:0] sum;
   logic [30:0] pre_sum;

   logic signed [48:0] vel_s;
   logic [7:0]  status_byte;
   logic [31:0] status_word;

   div_if div ();

   // Record word decode
   function automatic logic is_rec(input logic [7:0] a);
      is_rec = (a <= ADDR_REC4) && (a[1:0] == 2'b00);
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_sync_q[1];

   cfg_decoder u_dec (
      .rec_in         (s_q.rec),
      .cfg_out        (dec_cfg),
      .valid_out      (dec_valid),
      .nondefault_out (dec_nondefault)
   );

   serial_divider u_div (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_sync_n),
      .ce_in    (ce_in),
      .div      (div.slave)
   );

   assign div.start    = s_q.div_start;
   assign div.dividend = s_q.div_a;
   assign div.divisor  = s_q.div_b;

   always_comb begin
      s_d           = s_q;
      s_d.div_start = 1'b0;
      sum           = 31'h0;
      pre_sum       = 31'h0;
      revs_limit    = s_q.grade_high ? REVS_LIMIT_HIGH : REVS_LIMIT_LOW;

      // Scaling sequence
      case (s_q.fsm)
         ST_IDLE: begin
            if (s_q.commit_pend) begin
               s_d.commit_pend = 1'b0;
               if (dec_valid) begin
                  s_d.cfg       = dec_cfg;
                  s_d.offset    = 30'h0;
                  s_d.param_err = 1'b0;
                  if (dec_nondefault && (off_revs_in > revs_limit)) begin
                     s_d.scale_err = 1'b1;
                     s_d.alarm     = 1'b1;
                  end
               end else begin
                  s_d.param_err = 1'b1;
               end

            end else if (s_q.preset_pend) begin
               s_d.preset_pend = 1'b0;
               if (s_q.preset_val >= {2'b00, s_q.cfg.range}) begin
                  s_d.preset_err = 1'b1;
               end else begin
                  pre_sum = {1'b0, s_q.preset_val[29:0]} + {1'b0, s_q.cfg.range}
                          - {1'b0, s_q.base};
                  if (pre_sum >= {1'b0, s_q.cfg.range}) begin
                     pre_sum = pre_sum - {1'b0, s_q.cfg.range};
                  end
                  s_d.offset     = pre_sum[29:0];
                  s_d.position   = s_q.preset_val;
                  s_d.preset_err = 1'b0;
                  s_d.scale_err  = 1'b0;
                  s_d.alarm      = 1'b0;
               end
            end else begin

               // Raw turns times range times denominator
               s_d.div_a = 80'(raw_pos_in) * 80'(s_q.cfg.range)
                         * 80'(s_q.cfg.den);
               s_d.div_b = 32'({s_q.cfg.num, {FRAC_BITS{1'b0}}});
               s_d.div_start = 1'b1;
               s_d.fsm       = ST_DIV1;
            end
         end

         ST_DIV1: begin
            if (div.done) begin
               s_d.div_a     = div.quot;
               s_d.div_b     = {2'b00, s_q.cfg.range};
               s_d.div_start = 1'b1;
               s_d.fsm       = ST_DIV2;
            end
         end

         ST_DIV2: begin
            if (div.done) begin
               if (s_q.cfg.dir || (div.rem == 32'h0)) begin
                  s_d.base = div.rem[29:0];
               end else begin
                  s_d.base = s_q.cfg.range - div.rem[29:0];
               end
               s_d.fsm = ST_APPLY;
            end
         end

         ST_APPLY: begin
            sum = {1'b0, s_q.base} + {1'b0, s_q.offset};
            if (sum >= {1'b0, s_q.cfg.range}) begin
               sum = sum - {1'b0, s_q.cfg.range};
            end
            s_d.position = {2'b00, sum[29:0]};
            s_d.fsm      = ST_IDLE;
         end

         default: begin
            s_d.fsm = ST_IDLE;
         end
      endcase

      // Velocity sign and saturation
      vel_s = s_q.cfg.dir ? 49'(signed'(vel_raw_in))
                          : -49'(signed'(vel_raw_in));
      if (vel_s > VEL_MAX) begin
         s_d.velocity = 32'h7fffffff;
         s_d.vel_err  = 1'b1;
      end else if (vel_s < VEL_MIN) begin
         s_d.velocity = 32'h80000000;
         s_d.vel_err  = 1'b1;
      end else begin
         s_d.velocity = vel_s[31:0];
         s_d.vel_err  = 1'b0;
      end

      // Status assembly
      status_byte                  = 8'h00;
      status_byte[STAT_VEL_ERR]    = s_q.vel_err;
      status_byte[STAT_PRESET_ERR] = s_q.preset_err;
      status_byte[STAT_SCALE_ERR]  = s_q.scale_err;

      status_word                  = {24'h0, status_byte};
      status_word[STAT_PARAM_ERR]  = s_q.param_err;
      status_word[STAT_BUSY]       = s_q.commit_pend | s_q.preset_pend;
      status_word[STAT_ALARM]      = s_q.alarm;

      // Register writes, last so they win
      if (wr_in) begin
         if (is_rec(addr_in)) begin
            s_d.rec[addr_in[4:2]] = wdata_in;
         end else if (addr_in == ADDR_CTRL) begin
            if (wdata_in[CTRL_COMMIT_BIT]) begin
               s_d.commit_pend = 1'b1;
            end
            if (wdata_in[CTRL_PRESET_BIT]) begin
               s_d.preset_pend = 1'b1;
            end
            s_d.grade_high = wdata_in[CTRL_GRADE_BIT];
         end else if (addr_in == ADDR_PRESET) begin
            s_d.preset_val = wdata_in;
         end
      end

      // Register reads, one-cycle data
      s_d.rdata = 32'h0;
      if (rd_in) begin
         if (is_rec(addr_in)) begin
            s_d.rdata = s_q.rec[addr_in[4:2]];
         end else begin
            case (addr_in)
               ADDR_CTRL:     s_d.rdata = {29'h0, s_q.grade_high, 2'b00};
               ADDR_PRESET:   s_d.rdata = s_q.preset_val;
               ADDR_STATUS:   s_d.rdata = status_word;
               ADDR_POSITION: s_d.rdata = s_q.position;
               ADDR_VELOCITY: s_d.rdata = s_q.velocity;
               ADDR_ALARM:    s_d.rdata = s_q.alarm ? {16'h0, ALARM_SCALING}
                                                    : 32'h0;
               default:       s_d.rdata = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_q          <= '0;
         s_q.fsm      <= ST_IDLE;
         s_q.cfg      <= CFG_RESET;
         s_q.rec      <= REC_RESET;
         s_q.position <= 32'h0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end

   // Outputs straight from state flops
   assign rdata_out       = s_q.rdata;
   assign position_out    = s_q.position;
   assign velocity_out    = s_q.velocity;
   assign status_byte_out = {s_q.scale_err, 3'b000, s_q.preset_err, 2'b00, s_q.vel_err};

   assign alarm_out       = s_q.alarm;
   assign alarm_type_out  = s_q.alarm ? ALARM_SCALING : 16'h0000;
   assign param_err_out   = s_q.param_err;

   assign vel_unit_out    = s_q.cfg.vel_unit;
   assign filt_level_out  = s_q.cfg.filt_level;
   assign filt_dyn_out    = s_q.cfg.filt_dyn;
   assign vel_factor_out  = s_q.cfg.vel_factor;
   assign int_time_out    = s_q.cfg.int_time;
   assign window_out      = s_q.cfg.window;
endmodule

/* File: pkg/scale_pkg.sv */
// Constants and types of the position scaling block
//
// Behaviour
// - Byte 0 bit 0: 0 descending, 1 ascending
// - Position counts 0 to range minus one, wraps
// - Range bytes 1-4, 2..536870912, default 536870912
// - Numerator bytes 5-8, 1..256000, default 65536
// - Denominator bytes 9-12, 1..16384, default 1
// - Numerator over denominator sets revolutions per wrap
// - Byte 13: velocity unit, filter level, type
// - Window bytes 18-19, 50..4000, default 1000
// - Nondefault scaling: 3200/320 unpowered revolutions lose zero
// - Restart past limit: alarm 8211, status bit 7
// - Only successful preset clears alarm and flag
// - Position from raw, offset, direction, gear
// - Preset outside range rejected, status bit 3
// - Velocity overflow saturates, status bit 0
package scale_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_REC0     = 8'h00;
   localparam logic [7:0] ADDR_REC4     = 8'h10;
   localparam logic [7:0] ADDR_CTRL     = 8'h14;
   localparam logic [7:0] ADDR_PRESET   = 8'h18;
   localparam logic [7:0] ADDR_STATUS   = 8'h1c;
   localparam logic [7:0] ADDR_POSITION = 8'h20;
   localparam logic [7:0] ADDR_VELOCITY = 8'h24;
   localparam logic [7:0] ADDR_ALARM    = 8'h28;

   // Control and status bit positions
   localparam int CTRL_COMMIT_BIT  = 0;
   localparam int CTRL_PRESET_BIT  = 1;
   localparam int CTRL_GRADE_BIT   = 2;
   localparam int STAT_VEL_ERR     = 0;
   localparam int STAT_PRESET_ERR  = 3;
   localparam int STAT_SCALE_ERR   = 7;
   localparam int STAT_PARAM_ERR   = 8;
   localparam int STAT_BUSY        = 9;
   localparam int STAT_ALARM       = 10;

   // Record reset value, big-endian words
   localparam logic [4:0][31:0] REC_RESET = {
      32'h006403e8, 32'h01010001, 32'h00000000, 32'h00000100, 32'h01200000};

   // Parameter limits and defaults
   localparam logic [31:0] RANGE_MIN   = 32'h00000002;
   localparam logic [31:0] RANGE_MAX   = 32'h20000000;
   localparam logic [31:0] NUM_MAX     = 32'h0003e800;
   localparam logic [31:0] DEN_MAX     = 32'h00004000;
   localparam logic [31:0] NUM_DEFAULT = 32'h00010000;
   localparam logic [31:0] DEN_DEFAULT = 32'h00000001;
   localparam logic [2:0]  UNIT_MAX    = 3'h3;
   localparam logic [3:0]  FILT_MAX    = 4'ha;
   localparam logic [15:0] FACTOR_MAX  = 16'h03e8;
   localparam logic [15:0] ITIME_MAX   = 16'h03e8;
   localparam logic [15:0] WINDOW_MIN  = 16'h0032;
   localparam logic [15:0] WINDOW_MAX  = 16'h0fa0;

   // Unpowered revolution limits and alarm code
   localparam logic [31:0] REVS_LIMIT_LOW  = 32'd3200;
   localparam logic [31:0] REVS_LIMIT_HIGH = 32'd320;
   localparam logic [15:0] ALARM_SCALING   = 16'd8211;

   // Single-turn resolution of the raw position
   localparam int FRAC_BITS = 13;

   // Velocity limits
   localparam logic signed [48:0] VEL_MAX = 49'sh7fff_ffff;
   localparam logic signed [48:0] VEL_MIN = -49'sh8000_0000;

   typedef struct packed {
      logic        dir;
      logic [29:0] range;
      logic [17:0] num;
      logic [14:0] den;
      logic [2:0]  vel_unit;
      logic [3:0]  filt_level;
      logic        filt_dyn;
      logic [15:0] vel_factor;
      logic [15:0] int_time;
      logic [15:0] window;
   } cfg_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_DIV1  = 4'b0010,
      ST_DIV2  = 4'b0100,
      ST_APPLY = 4'b1000
   } fsm_t;

   // One record byte, big-endian
   function automatic logic [7:0] rec_byte(input logic [4:0][31:0] rec, input int idx);
      rec_byte = rec[idx / 4][31 - 8 * (idx % 4) -: 8];
   endfunction

endpackage

/* File: pkg/div_if.sv */
// Request and answer group of the serial divider
`timescale 1ns/1ps
interface div_if;
   logic        start;
   logic [79:0] dividend;
   logic [31:0] divisor;
   logic        done;
   logic [79:0] quot;
   logic [31:0] rem;

   modport master (output start, output dividend, output divisor,
                   input done, input quot, input rem);
   modport slave  (input start, input dividend, input divisor,
                   output done, output quot, output rem);
endinterface

/* File: hw/cfg_decoder.sv */
// Decodes and range-checks the parameter record
`timescale 1ns/1ps
module cfg_decoder
   import scale_pkg::*;
(
   // Record
   input  wire logic [4:0][31:0] rec_in,
   // Decoded
   output cfg_t                  cfg_out,
   output logic                  valid_out,
   output logic                  nondefault_out
);
   logic [31:0] range_w;
   logic [31:0] num_w;
   logic [31:0] den_w;
   logic [7:0]  vel_b;
   logic [15:0] factor_w;
   logic [15:0] itime_w;
   logic [15:0] window_w;

   always_comb begin
      range_w  = {rec_in[0][23:0], rec_in[1][31:24]};
      num_w    = {rec_in[1][23:0], rec_in[2][31:24]};
      den_w    = {rec_in[2][23:0], rec_in[3][31:24]};
      vel_b    = rec_byte(rec_in, 13);
      factor_w = rec_in[3][15:0];
      itime_w  = rec_in[4][31:16];
      window_w = rec_in[4][15:0];

      cfg_out.dir        = rec_in[0][24];
      cfg_out.range      = range_w[29:0];
      cfg_out.num        = num_w[17:0];
      cfg_out.den        = den_w[14:0];
      cfg_out.vel_unit   = vel_b[2:0];
      cfg_out.filt_level = vel_b[6:3];
      cfg_out.filt_dyn   = vel_b[7];
      cfg_out.vel_factor = factor_w;
      cfg_out.int_time   = itime_w;
      cfg_out.window     = window_w;

      valid_out = (range_w >= RANGE_MIN) && (range_w <= RANGE_MAX)
               && (num_w != 32'h0) && (num_w <= NUM_MAX)
               && (den_w != 32'h0) && (den_w <= DEN_MAX)
               && (vel_b[2:0] <= UNIT_MAX) && (vel_b[6:3] <= FILT_MAX)
               && (factor_w != 16'h0) && (factor_w <= FACTOR_MAX)
               && (itime_w != 16'h0) && (itime_w <= ITIME_MAX)
               && (window_w >= WINDOW_MIN) && (window_w <= WINDOW_MAX);

      nondefault_out = (range_w != RANGE_MAX) || (num_w != NUM_DEFAULT)
                    || (den_w != DEN_DEFAULT);
   end
endmodule

/* File: hw/serial_divider.sv */
// Restoring serial divider
`timescale 1ns/1ps
module serial_divider
   import scale_pkg::*;
(
   // Clock, reset, enable
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   // Request and answer
   div_if.slave      div
);
   typedef struct packed {
      logic        busy;
      logic [6:0]  cnt;
      logic [79:0] q;
      logic [31:0] r;
      logic [31:0] d;
      logic        done;
   } div_state_t;

   div_state_t s_q;
   div_state_t s_d;
   logic [32:0] trial;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      trial    = {s_q.r, s_q.q[79]};
      if (div.start) begin
         s_d.busy = 1'b1;
         s_d.cnt  = 7'd80;
         s_d.q    = div.dividend;
         s_d.r    = 32'h0;
         s_d.d    = div.divisor;
      end else if (s_q.busy) begin
         s_d.q = {s_q.q[78:0], 1'b0};
         if (trial >= {1'b0, s_q.d}) begin
            trial     = trial - {1'b0, s_q.d};
            s_d.q[0]  = 1'b1;
         end
         s_d.r   = trial[31:0];
         s_d.cnt = s_q.cnt - 7'd1;
         if (s_q.cnt == 7'd1) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end

   assign div.done = s_q.done;
   assign div.quot = s_q.q;
   assign div.rem  = s_q.r;
endmodule

/* File: testbench/encoder_position_scaling_sva.sv */
// Property checker for position scaling
`timescale 1ns/1ps
module epos_checker
   import scale_pkg::*;
(
   // Inputs
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic [7:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic [47:0] vel_raw_in,
   // Outputs
   input wire logic [31:0] velocity_out,
   input wire logic [7:0]  status_byte_out,
   input wire logic        alarm_out,
   input wire logic [15:0] alarm_type_out,
   input wire logic        param_err_out,
   input wire logic [2:0]  vel_unit_out,
   input wire logic [3:0]  filt_level_out,
   input wire logic [15:0] vel_factor_out,
   input wire logic [15:0] int_time_out,
   input wire logic [15:0] window_out
);
   logic [2:0] live_q;
   logic [9:0] since_q;
   // Settle and preset age
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         live_q  <= 3'h0;
         since_q <= 10'h3ff;
      end else begin
         live_q <= {live_q[1:0], 1'b1};
         if (wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_PRESET_BIT]) begin
            since_q <= 10'h000;
         end else if (since_q != 10'h3ff) begin
            since_q <= since_q + 10'h001;
         end
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   AST_ALARM_TYPE: assert property (alarm_type_out == (alarm_out ? ALARM_SCALING : 16'h0000))
      else $error("alarm type wrong");
   AST_ALARM_FLAG: assert property (alarm_out == status_byte_out[STAT_SCALE_ERR])
      else $error("alarm flag mismatch");
   AST_ALARM_CLEAR: assert property ($fell(alarm_out) |-> since_q < 10'd400)
      else $error("clear without preset");
   AST_VEL_OVER: assert property (live_q[2] && $signed(vel_raw_in) > 48'sh8000_0000
      |=> status_byte_out[STAT_VEL_ERR] && velocity_out inside {32'h7fffffff, 32'h80000000})
      else $error("no saturation");
   AST_VEL_FLAG: assert property (status_byte_out[STAT_VEL_ERR]
      |-> velocity_out inside {32'h7fffffff, 32'h80000000})
      else $error("flag without limit");
   AST_WINDOW: assert property (window_out >= WINDOW_MIN && window_out <= WINDOW_MAX)
      else $error("window range");
   AST_VEL_CFG: assert property (vel_factor_out inside {[1:1000]} && int_time_out inside {[1:1000]})
      else $error("velocity config range");
   AST_FORMAT: assert property (vel_unit_out <= UNIT_MAX && filt_level_out <= FILT_MAX)
      else $error("format range");
   AST_REJECT: assert property ($rose(param_err_out) |-> $stable(window_out) && $stable(vel_factor_out))
      else $error("reject changed config");
   AST_RSV_BITS: assert property (status_byte_out[6:4] == 3'h0 && status_byte_out[2:1] == 2'h0)
      else $error("reserved bits set");
   COV_ALARM: cover property ($rose(alarm_out));
   COV_CLEAR: cover property ($fell(alarm_out));
   COV_REJECT: cover property ($rose(param_err_out));
   COV_VEL: cover property ($rose(status_byte_out[STAT_VEL_ERR]));
endmodule

bind encoder_position_scaling epos_checker chk (.*);

/* File: testbench/station_model.sv */
// Station model: register master, record sender
`timescale 1ns/1ps
module station_model
   import scale_pkg::*;
(
   // Clock and read data
   input  wire logic        clk_in,
   input  wire logic [31:0] rdata_in,
   // Register port
   output logic [7:0]       addr_out = 8'h00,
   output logic [31:0]      wdata_out = 32'h0,
   output logic             wr_out = 1'b0,
   output logic             rd_out = 1'b0
);
   // Idle bus shows inverted last value
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
      addr_out <= ~a;
      @(negedge clk_in);
      d = rdata_in;
   endtask
   // Whole record, five big-endian words
   task automatic send_record(input logic dir, input logic [31:0] rng, num, den,
                              input logic [7:0] fmt, input logic [15:0] fac, itm, win);
      logic [159:0] rec;
      rec = {7'h00, dir, rng, num, den, fmt, fac, itm, win};
      for (int k = 0; k < 5; k++) begin
         wr32(8'(4 * k), rec[159 - 32 * k -: 32]);
      end
   endtask
endmodule

/* File: testbench/encoder_position_scaling_tb_top.sv */
// Testbench for position scaling
`timescale 1ns/1ps
module encoder_position_scaling_tb_top
   import scale_pkg::*;
;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in, rdata_out, position_out, velocity_out;
   logic        wr_in, rd_in, alarm_out, param_err_out, filt_dyn_out;
   logic [31:0] raw_pos_in = 32'h0001_2345;
   logic [31:0] off_revs_in = 32'h0;
   logic [47:0] vel_raw_in = 48'h0;
   logic [7:0]  status_byte_out;
   logic [15:0] alarm_type_out, vel_factor_out, int_time_out, window_out;
   logic [2:0]  vel_unit_out;
   logic [3:0]  filt_level_out;
   int          fails = 0;
   int          checked = 0;
   localparam logic [159:0] DEF_REC = {8'h01, 32'd536870912, 32'd65536, 32'd1, 8'h01,
                                      16'd1, 16'd100, 16'd1000};

   always #5 clk_sys_in = ~clk_sys_in;

   station_model st (.clk_in(clk_sys_in), .rdata_in(rdata_out), .addr_out(addr_in),
                     .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));

   encoder_position_scaling dut (.ce_in(1'b1), .*);

   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [31:0] exp_pos(input logic [31:0] raw, rng, num, den, input logic dir);
      logic [95:0] s;
      s = (({64'h0, raw} * rng * den) / ({64'h0, num} * 96'd8192)) % rng;
      exp_pos = 32'((dir || s == 96'h0) ? s : rng - s);
   endfunction

   // Command and settle
   task automatic run_cmd(input logic [31:0] c);
      logic [31:0] s;
      st.wr32(ADDR_CTRL, c);
      for (int i = 0; i < 100; i++) begin
         st.rd32(ADDR_STATUS, s);
         if (s[STAT_BUSY] === 1'b0) break;
      end
      chk("busy", 32'h0, 32'(s[STAT_BUSY]));
      repeat (400) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask

   task automatic s_reset();
      logic [31:0] w;
      repeat (400) @(negedge clk_sys_in);
      for (int k = 0; k < 5; k++) begin
         st.rd32(8'(4 * k), w);
         chk("record word", DEF_REC[159 - 32 * k -: 32], w);
      end
      st.rd32(8'h2c, w);
      chk("unmapped", 32'h0, w);
      chk("position", 32'h0001_2345, position_out);
      chk("unit", 32'h1, 32'(vel_unit_out));
      chk("window", 32'd1000, 32'(window_out));
      chk("time", 32'd100, 32'(int_time_out));
   endtask

   task automatic s_velocity();
      logic [47:0] v [4] = '{48'h0001_0000_0000, 48'hffff_8000_0000, 48'hffff_7fff_ffff, 48'h4d2};
      logic [31:0] e [4] = '{32'h7fffffff, 32'h80000000, 32'h80000000, 32'h000004d2};
      logic        f [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_in);
         vel_raw_in <= v[i];
         repeat (3) @(negedge clk_sys_in);
         chk("velocity", e[i], velocity_out);
         chk("velocity error", 32'(f[i]), 32'(status_byte_out[STAT_VEL_ERR]));
      end
   endtask

   task automatic s_gear();
      logic        d [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      logic [31:0] r [5] = '{32'd1000, 32'd1000, 32'd1000, 32'd1000, 32'd2};
      logic [31:0] n [5] = '{32'd1, 32'd1, 32'd3, 32'd256000, 32'd1};
      logic [31:0] q [5] = '{32'd1, 32'd1, 32'd2, 32'd16384, 32'd3};
      logic [7:0]  f [5] = '{8'h01, 8'hd3, 8'h00, 8'h02, 8'h01};
      logic [15:0] fc, it, w;
      @(posedge clk_sys_in);
      raw_pos_in <= 32'h0000_4800;
      vel_raw_in <= 48'h5;
      for (int i = 0; i < 5; i++) begin
         fc = (i == 3) ? 16'd1000 : 16'(1 + i);
         it = (i == 3) ? 16'd1 : 16'(1000 - i);
         w = (i == 3) ? 16'd4000 : 16'(50 + i);
         st.send_record(d[i], r[i], n[i], q[i], f[i], fc, it, w);
         run_cmd(32'h1);
         chk("position", exp_pos(32'h4800, r[i], n[i], q[i], d[i]), position_out);
         chk("unit", 32'(f[i][2:0]), 32'(vel_unit_out));
         chk("filter", 32'(f[i][7:3]), {27'h0, filt_dyn_out, filt_level_out});
         chk("factor", 32'(fc), 32'(vel_factor_out));
         chk("time", 32'(it), 32'(int_time_out));
         chk("window", 32'(w), 32'(window_out));
         chk("param error", 32'h0, 32'(param_err_out));
         chk("velocity sign", d[i] ? 32'h5 : 32'hfffffffb, velocity_out);
      end
   endtask

   task automatic s_invalid();
      logic [31:0] r, n, q;
      logic [7:0]  f;
      logic [15:0] fc, it, w;
      st.send_record(1'b1, 32'd1000, 32'd3, 32'd2, 8'h01, 16'd1, 16'd100, 16'd60);
      run_cmd(32'h1);
      for (int i = 0; i < 11; i++) begin
         {r, n, q, f, fc, it, w} = {32'd1000, 32'd3, 32'd2, 8'h01, 16'd1, 16'd100, 16'd77};
         case (i)
            0: r = 32'd1;
            1: r = 32'd536870913;
            2: n = 32'd0;
            3: n = 32'd256001;
            4: q = 32'd0;
            5: q = 32'd16385;
            6: w = 16'd49;
            7: w = 16'd4001;
            8: f = 8'h59;
            9: fc = 16'd1001;
            default: it = 16'd1001;
         endcase
         st.send_record(1'b1, r, n, q, f, fc, it, w);
         run_cmd(32'h1);
         chk("param error", 32'h1, 32'(param_err_out));
         chk("window kept", 32'd60, 32'(window_out));
      end
   endtask

   task automatic s_alarm();
      logic [31:0] w;
      off_revs_in <= 32'd5000;
      st.send_record(1'b1, 32'd536870912, 32'd65536, 32'd1, 8'h01, 16'd1, 16'd100, 16'd1000);
      run_cmd(32'h1);
      chk("alarm dflt", 32'h0, 32'(alarm_out));
      off_revs_in <= 32'd3200;
      st.send_record(1'b1, 32'd1000, 32'd1, 32'd1, 8'h01, 16'd1, 16'd100, 16'd1000);
      run_cmd(32'h1);
      chk("alarm 3200", 32'h0, 32'(alarm_out));
      off_revs_in <= 32'd3201;
      run_cmd(32'h1);
      chk("alarm 3201", 32'h1, 32'(alarm_out));
      chk("status", 32'h80, 32'(status_byte_out));
      st.rd32(ADDR_ALARM, w);
      chk("alarm type", 32'd8211, w);
      st.wr32(ADDR_PRESET, 32'd1000);
      run_cmd(32'h2);
      chk("preset err", 32'h88, 32'(status_byte_out));
      chk("alarm kept", 32'h1, 32'(alarm_out));
      st.wr32(ADDR_PRESET, 32'd999);
      run_cmd(32'h2);
      chk("preset pos", 32'd999, position_out);
      chk("status clr", 32'h0, 32'(status_byte_out));
      off_revs_in <= 32'd321;
      run_cmd(32'h5);
      chk("alarm 321", 32'h1, 32'(alarm_out));
      off_revs_in <= 32'd320;
      run_cmd(32'h5);
      chk("alarm held", 32'h1, 32'(alarm_out));
   endtask

   initial begin
      repeat (4) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      s_reset();
      s_velocity();
      s_gear();
      s_invalid();
      s_alarm();
      results();
   end

   initial begin
      #400_000;
      fails++;
      results();
   end
endmodule
